// [rtl/clk_guard_defines.svh]
// Constants for the clock safeguard and reset controller
`ifndef CLK_GUARD_DEFINES_SVH
`define CLK_GUARD_DEFINES_SVH
`define ADC_CTRL_ADDR     8'hd1
`define ADC_CTRL_RESET    8'h40
`define OSC_OFF_BIT       2
`define OPT_SAFEGUARD_BIT 0
`define OPT_OSC_RC_BIT    6
`define DIV_TIMER         4'd12
`define DIV_CORE          4'd13
`define DIV_ART_SLOW      2'd3
`define RESET_DELAY       12'd2048
`define MISS_LIMIT        4'd8
`define SPIKE_MIN_GAP     4'd2
`define RESTART_DELAY     8'd64
`endif

// [rtl/clk_guard_pkg.sv]
// Types for the clock safeguard and reset controller
package clk_guard_pkg;
  typedef enum logic [1:0] {
    SRC_MAIN    = 2'b00,
    SRC_BACKUP  = 2'b01,
    SRC_RESTART = 2'b10
  } clk_src_t;
endpackage

// [rtl/clock_safeguard_reset_ctrl.sv]
// Clock derivation, oscillator safeguard and reset collection
//
// Overview of operation
// - Timer, watchdog and converter clock is internal clock divided by twelve.
// - Core and serial clock is internal clock divided by thirteen.
// - Auto-reload timer clock is internal clock divided by one or three.
// - Option bit selects RC network or crystal/resonator/external main oscillator.
// - Safeguard on and oscillator-off set: stop main, run backup oscillator.
// - Clearing oscillator-off or reset restarts main after start-up delay.
// - Oscillator-off is bit 2 of converter control; one disables main.
// - Without safeguard option, oscillator-off writes do not affect main.
// - Active safeguard suppresses spikes so clock stays below its maximum.
// - Over-frequency is treated as spikes and cycles are dropped.
// - Safeguard and backup oscillator exist only with safeguard option.
// - Backup starts one backup period after first missing main edge.
// - Backup clock runs code, interrupts, wait and stop normally, slower.
// - Reset delay counts backup clock until main starts, then main takes over.
// - Backup oscillator is switched off once main oscillator runs.
// - Converter control at 0xd1, read/write, resets to 0x40.
// - Low-voltage detector works only when its option bit is set.
// - Detector holds static reset whenever supply is below threshold.
// - Detector falling threshold is below rising threshold (hysteresis).
// - During low-voltage reset the reset pin is driven low.
// - Reset sources: external pin low, watchdog, low-voltage detector.
// - Safeguard enable option is low option byte bit 0; one enables.
// - Oscillator type option is low option byte bit 6; one selects RC.
// - Detector option bit at one enables the detector.
//
// The address-and-strobe port was chosen for this implementation.
`include "clk_guard_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module clock_safeguard_reset_ctrl (
  input  wire logic       mclk,             // System sampling clock, 25 MHz
  input  wire logic       reset_n,          // Asynchronous reset, active low
  input  wire logic [7:0] option_low,       // Low option byte
  input  wire logic       lvd_option,       // Detector option bit
  input  wire logic       main_osc_in,      // Main oscillator level (pin)
  input  wire logic       backup_osc_in,    // Backup oscillator level
  input  wire logic       supply_above_rise,// Supply above rising threshold
  input  wire logic       supply_above_fall,// Supply above falling threshold
  input  wire logic       reset_pin_in,     // Reset pin level
  input  wire logic       watchdog_reset,   // Watchdog reset pulse
  input  wire logic [7:0] addr,             // Register address
  input  wire logic [7:0] wdata,            // Register write data
  input  wire logic       wr,               // Write strobe
  input  wire logic       rd,               // Read strobe
  output logic      [7:0] rdata,            // Read data, cycle after strobe
  output logic            int_clk,          // Internal clock level
  output logic            timer_clk_en,     // Internal clock divided by 12
  output logic            core_clk_en,      // Internal clock divided by 13
  output logic            art_clk_en,       // Internal clock divided by 1 or 3
  output logic            main_osc_enable,  // Main oscillator run request
  output logic            main_osc_rc_mode, // RC network selected
  output logic            backup_osc_enable,// Backup oscillator run request
  output logic            using_backup,     // Backup is the clock source
  output logic            reset_pin_out,    // Reset pin drive value (low)
  output logic            reset_pin_oe_n,   // Reset pin enable, low drives
  output logic            chip_reset        // Internal reset to the core
);
  import clk_guard_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers, two flops each before any logic reads them
  // Reset levels match the edge detectors and idle pins, so no false edge
  logic [6:0] sync1;
  logic [6:0] sync2;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= 7'h1d;
      sync2 <= 7'h1d;
    end else begin
      sync1 <= {main_osc_in, backup_osc_in, supply_above_rise, supply_above_fall,
                reset_pin_in, watchdog_reset, 1'b1};
      sync2 <= sync1;
    end
  end
  logic main_s;
  logic back_s;
  logic rise_s;
  logic fall_s;
  logic pin_s;
  logic wdg_s;
  assign main_s = sync2[6];
  assign back_s = sync2[5];
  assign rise_s = sync2[4];
  assign fall_s = sync2[3];
  assign pin_s  = sync2[2];
  assign wdg_s  = sync2[1];

  // Previous levels for edge detection, read from the second flop only
  logic main_d;
  logic back_d;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      main_d <= 1'b0;
      back_d <= 1'b0;
    end else begin
      main_d <= main_s;
      back_d <= back_s;
    end
  end
  logic main_edge;
  logic back_rise;
  assign main_edge = main_s != main_d;
  assign back_rise = back_s && !back_d;

  //////////////////////////////////////////////////////////////////////////
  // Option bits
  logic safeguard_on;
  logic lvd_on;
  assign safeguard_on = option_low[`OPT_SAFEGUARD_BIT];
  assign lvd_on       = lvd_option;

  // Converter control register; the oscillator-off bit and bit 0 (auto-reload divide by three) act here
  logic [7:0] adc_control_reg;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) adc_control_reg <= `ADC_CTRL_RESET;
    else if (chip_reset) adc_control_reg <= `ADC_CTRL_RESET;
    else if (wr && addr == `ADC_CTRL_ADDR) adc_control_reg <= wdata;
  end
  logic main_osc_off_bit;
  assign main_osc_off_bit = adc_control_reg[`OSC_OFF_BIT];

  // Read port; unmapped addresses read zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) rdata <= 8'h00;
    else if (rd && addr == `ADC_CTRL_ADDR) rdata <= adc_control_reg;
    else rdata <= 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  // Missing-edge watchdog on the main oscillator
  logic [3:0] miss_cnt;
  logic       main_missing;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) miss_cnt <= 4'h0;
    else if (main_edge) miss_cnt <= 4'h0;
    else if (miss_cnt != `MISS_LIMIT) miss_cnt <= miss_cnt + 4'h1;
  end
  assign main_missing = miss_cnt == `MISS_LIMIT;

  //////////////////////////////////////////////////////////////////////////
  // Source selection state machine
  clk_src_t   src;
  logic [7:0] restart_cnt;
  logic       osc_off_req;
  assign osc_off_req = safeguard_on && main_osc_off_bit;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      src         <= SRC_RESTART;
      restart_cnt <= 8'h00;
    end else begin
      unique case (src)
        SRC_MAIN: begin
          // Switch on a backup rising edge: one backup period after the miss
          if (safeguard_on && (osc_off_req || main_missing) && back_rise)
            src <= SRC_BACKUP;
        end
        SRC_BACKUP: begin
          if (!safeguard_on) src <= SRC_RESTART;
          else if (!osc_off_req) begin
            src         <= SRC_RESTART;
            restart_cnt <= 8'h00;
          end
        end
        SRC_RESTART: begin
          // Start-up delay, then handover at a main edge so no short phase
          if (osc_off_req) src <= SRC_BACKUP;
          else if (!main_missing && restart_cnt != `RESTART_DELAY)
            restart_cnt <= restart_cnt + 8'h01;
          else if (restart_cnt == `RESTART_DELAY && main_edge && !main_s)
            src <= SRC_MAIN;
        end
        default: src <= SRC_RESTART;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      main_osc_enable   <= 1'b1;
      backup_osc_enable <= 1'b0;
      using_backup      <= 1'b0;
      main_osc_rc_mode  <= 1'b0;
    end else begin
      main_osc_enable   <= !osc_off_req;
      // Backup must run before the switch, else no backup edge ever comes
      backup_osc_enable <= safeguard_on &&
                           (src != SRC_MAIN || osc_off_req || main_missing);
      using_backup      <= src == SRC_BACKUP ||
                           (src == SRC_RESTART && safeguard_on);
      main_osc_rc_mode  <= option_low[`OPT_OSC_RC_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Internal clock edge: backup or main source, spike filtered
  logic [3:0] gap_cnt;
  logic       src_tick;
  logic       int_tick;
  assign src_tick = using_backup ? back_rise : (main_edge && main_s);
  // Spike filter drops ticks closer than the minimum gap
  assign int_tick = src_tick && (!safeguard_on || gap_cnt >= `SPIKE_MIN_GAP);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) gap_cnt <= 4'h0;
    else if (int_tick) gap_cnt <= 4'h0;
    else if (gap_cnt != 4'hf) gap_cnt <= gap_cnt + 4'h1;
  end
  // Whole clock periods only, so switching never shortens a phase
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) int_clk <= 1'b0;
    else if (int_tick) int_clk <= !int_clk;
  end

  //////////////////////////////////////////////////////////////////////////
  // Dividers, cleared by reset for a known phase
  logic [3:0] div12;
  logic [3:0] div13;
  logic [1:0] div3;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div12 <= 4'h0;
      div13 <= 4'h0;
      div3  <= 2'h0;
    end else if (chip_reset) begin
      div12 <= 4'h0;
      div13 <= 4'h0;
      div3  <= 2'h0;
    end else if (int_tick) begin
      div12 <= (div12 == `DIV_TIMER - 4'h1) ? 4'h0 : div12 + 4'h1;
      div13 <= (div13 == `DIV_CORE - 4'h1) ? 4'h0 : div13 + 4'h1;
      div3  <= (div3 == `DIV_ART_SLOW - 2'h1) ? 2'h0 : div3 + 2'h1;
    end
  end
  logic art_div3;
  assign art_div3 = adc_control_reg[0];
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timer_clk_en <= 1'b0;
      core_clk_en  <= 1'b0;
      art_clk_en   <= 1'b0;
    end else begin
      timer_clk_en <= int_tick && !chip_reset && div12 == `DIV_TIMER - 4'h1;
      core_clk_en  <= int_tick && !chip_reset && div13 == `DIV_CORE - 4'h1;
      art_clk_en   <= int_tick && !chip_reset &&
                      (!art_div3 || div3 == `DIV_ART_SLOW - 2'h1);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Low-voltage detector with hysteresis
  logic lvd_low;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) lvd_low <= 1'b1;
    else if (!lvd_on) lvd_low <= 1'b0;
    else if (lvd_low) lvd_low <= !rise_s;
    else lvd_low <= !fall_s;
  end

  // Reset collection and delay counted on internal clock ticks
  logic        any_reset;
  logic [11:0] delay_cnt;
  assign any_reset = !pin_s || wdg_s || lvd_low;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) delay_cnt <= 12'h000;
    else if (any_reset) delay_cnt <= 12'h000;
    else if (int_tick && delay_cnt != `RESET_DELAY) delay_cnt <= delay_cnt + 12'h001;
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      chip_reset     <= 1'b1;
      reset_pin_out  <= 1'b0;
      reset_pin_oe_n <= 1'b1;
    end else begin
      chip_reset     <= any_reset || delay_cnt != `RESET_DELAY;
      reset_pin_out  <= 1'b0;
      reset_pin_oe_n <= !(lvd_low || wdg_s);
    end
  end
endmodule // clock_safeguard_reset_ctrl
`default_nettype wire

// [test/clk_guard_properties.sv]
// Port assertions for the clock safeguard and reset controller
`timescale 1ns/1ps
`default_nettype none
`include "clk_guard_defines.svh"
module clk_guard_checker (
  input wire logic       mclk,              // Clock
  input wire logic       reset_n,           // Reset, active low
  input wire logic [7:0] option_low,        // Option byte
  input wire logic       lvd_option,        // Detector option
  input wire logic       supply_above_fall, // Above lower threshold
  input wire logic       reset_pin_in,      // Reset pin level
  input wire logic       watchdog_reset,    // Watchdog request
  input wire logic [7:0] addr,              // Address
  input wire logic [7:0] wdata,             // Write data
  input wire logic       wr,                // Write strobe
  input wire logic       rd,                // Read strobe
  input wire logic [7:0] rdata,             // Read data
  input wire logic       int_clk,           // Internal clock
  input wire logic       timer_clk_en,      // Divide by 12
  input wire logic       core_clk_en,       // Divide by 13
  input wire logic       main_osc_enable,   // Main run
  input wire logic       main_osc_rc_mode,  // RC selected
  input wire logic       backup_osc_enable, // Backup run
  input wire logic       using_backup,      // Backup is source
  input wire logic       reset_pin_oe_n,    // Pin drive, low drives
  input wire logic       chip_reset         // Core reset
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ////////////////////
  // Tick spacing and divider pulses
  a_spike_gap: assert property (option_low[0] && $changed(int_clk) |=> $stable(int_clk))
    else $error("internal clock ticked on consecutive cycles");
  a_timer_gap: assert property (timer_clk_en |=> !timer_clk_en [*8])
    else $error("timer pulse too soon");
  a_core_gap: assert property (core_clk_en |=> !core_clk_en [*8])
    else $error("core pulse too soon");
  // Oscillator control; register delays allow a few cycles
  a_osc_off_write: assert property (wr && addr == `ADC_CTRL_ADDR && wdata[`OSC_OFF_BIT]
    && option_low[0] && !chip_reset |-> ##[1:3] !main_osc_enable)
    else $error("main oscillator not stopped");
  a_no_guard: assert property (!option_low[0] && $stable(option_low) |-> main_osc_enable && !using_backup)
    else $error("safeguard acted while off");
  a_rc_mode: assert property ($stable(option_low) [*4] |-> main_osc_rc_mode == option_low[6])
    else $error("rc mode differs from option");
  a_backup_src: assert property (using_backup |-> backup_osc_enable)
    else $error("backup source while backup stopped");
  // Reset collection and register port
  a_src_reset: assert property (!reset_pin_in || watchdog_reset |-> ##[1:4] chip_reset)
    else $error("reset source ignored");
  a_lvd_pin: assert property (lvd_option && !supply_above_fall |-> ##[1:4] !reset_pin_oe_n)
    else $error("low supply does not drive pin");
  a_pin_reset: assert property (!reset_pin_oe_n |-> ##[0:2] chip_reset)
    else $error("pin driven without core reset");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  a_reset_value: assert property (rd && addr == `ADC_CTRL_ADDR && chip_reset |=> rdata == `ADC_CTRL_RESET)
    else $error("register not at reset value");
  c_backup: cover property (using_backup);
  c_timer: cover property (timer_clk_en);
  c_pin: cover property (!reset_pin_oe_n);
endmodule // clk_guard_checker
bind clock_safeguard_reset_ctrl clk_guard_checker u_clk_guard_checker (.mclk, .reset_n,
  .option_low, .lvd_option, .supply_above_fall, .reset_pin_in, .watchdog_reset, .addr,
  .wdata, .wr, .rd, .rdata, .int_clk, .timer_clk_en, .core_clk_en, .main_osc_enable,
  .main_osc_rc_mode, .backup_osc_enable, .using_backup, .reset_pin_oe_n, .chip_reset);
`default_nettype wire

// [test/osc_partner.sv]
// Model of the external crystal and the backup oscillator cell
`timescale 1ns/1ps
`default_nettype none
module osc_partner (
  input  wire logic mclk,      // Bench clock
  input  wire logic main_en,   // Main run request
  input  wire logic backup_en, // Backup run request
  input  wire logic broken,    // Injected crystal failure
  input  wire logic fast,      // Over-frequency, toggles each cycle
  output var  logic main_out,  // Main level
  output var  logic backup_out // Backup level
);
  logic [3:0] bcnt = 4'h0;
  logic       half = 1'b0;
  initial main_out = 1'b0;
  initial backup_out = 1'b0;
  // A stopped crystal holds its last level, as a real one does
  always @(posedge mclk) begin
    half <= !half;
    if (main_en && !broken && (fast || half)) begin
      main_out <= !main_out;
    end
    bcnt <= (bcnt == 4'h9) ? 4'h0 : bcnt + 4'h1;
    if (backup_en && bcnt == 4'h9) begin
      backup_out <= !backup_out;
    end
  end
endmodule // osc_partner
`default_nettype wire

// [test/clock_safeguard_reset_ctrl_tb_top.sv]
// Testbench for the clock safeguard and reset controller
`timescale 1ns/1ps
`default_nettype none
`include "clk_guard_defines.svh"
module clock_safeguard_reset_ctrl_tb_top;
  logic       mclk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] option_low = 8'h00;
  logic       lvd_option = 1'b0;
  logic       sup_r = 1'b1;
  logic       sup_f = 1'b1;
  logic       pin_drv = 1'b1;
  logic       watchdog_reset = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       broken = 1'b0;
  logic       fast = 1'b0;
  logic [7:0] rdata;
  logic       main_in, backup_in, int_clk, t_en, c_en, a_en, m_en, rc, b_en, use_b;
  logic       pin_out, oe_n, chip_reset;
  logic [7:0] v;
  int         miscompares = 0;
  int         n_checks = 0;
  int         cycles = 0;
  wire        reset_pin = oe_n ? pin_drv : pin_out; // Pulled up unless someone drives
  always #20 mclk = !mclk;
  clock_safeguard_reset_ctrl u_clock_safeguard_reset_ctrl (.mclk, .reset_n, .option_low,
    .lvd_option, .main_osc_in(main_in), .backup_osc_in(backup_in), .supply_above_rise(sup_r),
    .supply_above_fall(sup_f), .reset_pin_in(reset_pin), .watchdog_reset, .addr, .wdata, .wr,
    .rd, .rdata, .int_clk, .timer_clk_en(t_en), .core_clk_en(c_en), .art_clk_en(a_en),
    .main_osc_enable(m_en), .main_osc_rc_mode(rc), .backup_osc_enable(b_en),
    .using_backup(use_b), .reset_pin_out(pin_out), .reset_pin_oe_n(oe_n), .chip_reset);
  osc_partner u_osc_partner (.mclk, .main_en(m_en), .backup_en(b_en), .broken, .fast,
    .main_out(main_in), .backup_out(backup_in));
  ////////////////////
  // Comparison, selection and bus helpers
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: pick = chip_reset;
      1: pick = use_b;
      2: pick = oe_n;
      3: pick = m_en;
      4: pick = t_en;
      5: pick = c_en;
      default: pick = a_en;
    endcase
  endfunction
  // Bounded wait for a level; the sample taken at the end is the verdict
  task automatic wait_sig(input string what, input int s, input logic val, input int lim);
    for (int i = 0; i < lim && pick(s) !== val; i++) @(posedge mclk);
    check(what, {7'h0, val}, {7'h0, pick(s)});
  endtask
  // Internal clock toggles from one divider pulse to the next
  task automatic span(input string what, input int s, input logic [7:0] exp);
    logic [7:0] n;
    logic       p;
    n = 8'h00;
    do @(posedge mclk); while (pick(s) !== 1'b1);
    p = int_clk;
    do begin
      @(posedge mclk);
      n += {7'h0, int_clk !== p};
      p = int_clk;
    end while (pick(s) !== 1'b1);
    check(what, exp, n);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic do_reset(input logic [7:0] opt);
    reset_n <= 1'b0;
    option_low <= opt;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
  endtask
  ////////////////////
  // Scenarios
  task automatic t_regs_div;
    wr_reg(`ADC_CTRL_ADDR, 8'h55);
    rd_reg(`ADC_CTRL_ADDR, v);
    check("reg in reset", `ADC_CTRL_RESET, v);
    rd_reg(8'h20, v);
    check("unmapped", 8'h00, v);
    wait_sig("reset end", 0, 1'b0, 20000);
    span("timer span", 4, 8'd12);
    span("core span", 5, 8'd13);
    span("art fast", 6, 8'd1);
    wr_reg(`ADC_CTRL_ADDR, 8'h41);
    rd_reg(`ADC_CTRL_ADDR, v);
    check("reg rw", 8'h41, v);
    span("art slow", 6, 8'd3);
  endtask
  task automatic t_guard_off;
    wr_reg(`ADC_CTRL_ADDR, 8'h04);
    repeat (100) @(posedge mclk);
    check("main on", 8'h01, {7'h0, m_en});
    check("no backup", 8'h00, {7'h0, use_b});
  endtask
  task automatic t_guard_on;
    check("rc mode", 8'h01, {7'h0, rc});
    wr_reg(`ADC_CTRL_ADDR, 8'h04);
    wait_sig("main off", 3, 1'b0, 4);
    wait_sig("to backup", 1, 1'b1, 200);
    span("core on backup", 5, 8'd13);
    wr_reg(`ADC_CTRL_ADDR, 8'h00);
    wait_sig("main on", 3, 1'b1, 4);
    wait_sig("to main", 1, 1'b0, 400);
    repeat (4) @(posedge mclk);
    check("backup stop", 8'h00, {7'h0, b_en});
    broken <= 1'b1;
    wait_sig("fail", 1, 1'b1, 200);
    broken <= 1'b0;
    wait_sig("recover", 1, 1'b0, 400);
    fast <= 1'b1;
    span("core fast", 5, 8'd13);
    fast <= 1'b0;
  endtask
  task automatic t_resets;
    watchdog_reset <= 1'b1;
    @(posedge mclk);
    watchdog_reset <= 1'b0;
    wait_sig("watchdog", 0, 1'b1, 6);
    wait_sig("wd end", 0, 1'b0, 20000);
    lvd_option <= 1'b1;
    sup_r <= 1'b0;
    sup_f <= 1'b0;
    wait_sig("lvd pin", 2, 1'b0, 6);
    sup_f <= 1'b1;
    repeat (50) @(posedge mclk);
    check("hysteresis", 8'h01, {7'h0, chip_reset});
    sup_r <= 1'b1;
    wait_sig("lvd end", 2, 1'b1, 10);
    wait_sig("lvd done", 0, 1'b0, 20000);
  endtask
  task automatic finish_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Cut a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    do_reset(8'h00);
    t_regs_div();
    t_guard_off();
    do_reset(8'h41);
    wait_sig("reset end", 0, 1'b0, 20000);
    t_guard_on();
    t_resets();
    finish_test();
  end
endmodule // clock_safeguard_reset_ctrl_tb_top
`default_nettype wire
